// ### src/kwu_pkg.sv
// package for the keypad wake unit: register map, field positions, reset values
// assumes a 32-bit ahb-lite register bus, one word per register
package kwu_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] KWU_OFS_STATUS_CONTROL = 12'h000;
    localparam logic [11:0] KWU_OFS_PIN_ENABLE = 12'h004;
    localparam logic [11:0] KWU_OFS_POLARITY_SELECT = 12'h008;
    localparam logic [11:0] KWU_OFS_IRQ_STATUS = 12'h00C;
    localparam logic [11:0] KWU_OFS_IRQ_MASK = 12'h010;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int KWU_BIT_MODE = 0;
    localparam int KWU_BIT_IRQ_EN = 1;
    localparam int KWU_BIT_ACK = 2;
    localparam int KWU_BIT_FLAG = 3;
    localparam int KWU_NUM_BITS = 8;
    // implemented pin positions 5,4,2,1,0
    localparam logic [7:0] KWU_PIN_MASK = 8'h37;
    // event status bits: 0 edge seen, 1 level seen
    localparam int KWU_EVT_EDGE = 0;
    localparam int KWU_EVT_LEVEL = 1;
    localparam logic [1:0] KWU_EVT_MASK = 2'h3;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] KWU_RST_CTRL = 8'h00;
    localparam logic [7:0] KWU_RST_PINS = 8'h00;
    localparam logic [1:0] KWU_RST_EVT = 2'h0;
    localparam logic [31:0] KWU_RST_RDATA = 32'h0000_0000;
    // ------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------
    localparam logic [1:0] KWU_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] KWU_HTRANS_SEQ = 2'h3;
    localparam logic [2:0] KWU_HSIZE_WORD = 3'h2;
    localparam logic KWU_HRESP_OKAY = 1'b0;
    // data phase state, one-hot
    typedef enum logic [1:0]
    {
        KWU_PH_IDLE = 2'b01,
        KWU_PH_DATA = 2'b10
    } kwu_phase_type;
endpackage

// ### src/kwu_pin_detect.sv
// per-pin detector for the keypad wake unit
// assumes pin inputs already synchronous to hclk
`timescale 1ns/1ps
module kwu_pin_detect
    import kwu_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_en,
    input wire logic [7:0] pin_pol,
    output logic [7:0] edge_hit,
    output logic [7:0] level_hit
);
    // ------------------------------------------------------------
    // asserted-level view and previous sample
    // ------------------------------------------------------------
    logic [7:0] prev_asserted; // last cycle's asserted view
    logic [7:0] prev_valid; // pin enabled last cycle too
    wire logic [7:0] asserted = pin_in ~^ pin_pol; // pol 1 -> high asserts

    genvar i;
    generate
        for (i = 0; i < KWU_NUM_BITS; i++)
        begin : g_pin
            // previous sample; reset treats pins as deasserted-unknown
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    prev_asserted[i] <= 1'b0;
                    prev_valid[i] <= 1'b0;
                end
                else
                begin
                    prev_asserted[i] <= asserted[i];
                    prev_valid[i] <= pin_en[i] & KWU_PIN_MASK[i];
                end
            end
            // edge only after a deasserted sample while enabled
            assign edge_hit[i] = pin_en[i] & KWU_PIN_MASK[i] & prev_valid[i]
                                 & ~prev_asserted[i] & asserted[i];
            assign level_hit[i] = pin_en[i] & KWU_PIN_MASK[i] & asserted[i];
        end
    endgenerate

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_edge_needs_deassert;
        @(posedge hclk) disable iff (!hresetn)
        (|edge_hit) |-> ($past(~asserted) & asserted & pin_en) != 8'h00;
    endproperty
    a_edge_needs_deassert: assert property (p_edge_needs_deassert)
        else $error("edge reported without prior deasserted sample");
endmodule

// ### src/kwu_irq_status.sv
// sticky event status with mask, cleared by a read
// assumes one-cycle event pulses and a one-cycle read strobe
`timescale 1ns/1ps
module kwu_irq_status
    import kwu_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [1:0] evt,
    input wire logic rd_clear,
    input wire logic mask_we,
    input wire logic [1:0] mask_wdata,
    output logic [1:0] status,
    output logic [1:0] mask,
    output logic irq
);
    // ------------------------------------------------------------
    // sticky bits: a new event beats the read clear
    // ------------------------------------------------------------
    wire logic [1:0] next_status = (rd_clear ? KWU_RST_EVT : status) | evt;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            status <= KWU_RST_EVT;
            mask <= KWU_RST_EVT;
        end
        else
        begin
            status <= next_status;
            if (mask_we)
            begin
                mask <= mask_wdata & KWU_EVT_MASK;
            end
        end
    end

    assign irq = |(status & mask); // level, high while unmasked bit set

    property p_evt_sticks;
        @(posedge hclk) disable iff (!hresetn)
        evt[0] |=> status[0];
    endproperty
    a_evt_sticks: assert property (p_evt_sticks)
        else $error("event lost against read clear");
endmodule

// ### src/kwu_top.sv
// keypad wake unit: pin edge/level detection, one flag, ahb-lite registers
// assumes synchronous pin inputs and a single hclk domain
//
// Functional notes
// - flag bit 3, read-only, set on detect
// - acknowledge bit 2, write 1, reads 0
// - bit 1 gates the interrupt request
// - bit 0: edge only or edge+level; the stop wake_request still follows held levels in edge-only mode
// - per-pin enable bit gates detection
// - per-pin polarity: 1 rising/high, 0 falling/low
// - only bits 5,4,2,1,0 implemented
// - falling edge: sample 1 then 0
// - rising edge: sample 0 then 1
// - edge needs prior deasserted sample
// - edge mode: ack write clears flag
// - level mode: edge or level sets flag
// - level mode: ack clears only all deasserted
// - enabling a pin adds no pulls
// - detection continues, wake request in stop
`timescale 1ns/1ps
module kwu_top
    import kwu_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] wake_input_pin,
    input wire logic stop_mode,
    output logic kbd_irq,
    output logic wake_request,
    output logic evt_irq
);
    import kwu_pkg::*;

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    logic detect_flag; // status flag
    logic irq_enable; // request gate
    logic edge_level_mode; // 0 edges, 1 edges and levels
    logic [7:0] kbd_pin_enable; // per-pin enable
    logic [7:0] kbd_polarity_select; // per-pin polarity

    // ------------------------------------------------------------
    // bus address phase capture
    // ------------------------------------------------------------
    kwu_phase_type phase; // idle or data phase pending
    logic [11:0] ap_addr; // latched offset
    logic ap_write; // latched direction
    logic [31:0] hrdata_q; // registered read data

    wire logic ap_valid = hsel & hready & (htrans == KWU_HTRANS_NONSEQ || htrans == KWU_HTRANS_SEQ);
    wire logic dp_write = (phase == KWU_PH_DATA) & ap_write;
    wire logic hit_sc = (ap_addr == KWU_OFS_STATUS_CONTROL);
    wire logic hit_pe = (ap_addr == KWU_OFS_PIN_ENABLE);
    wire logic hit_ps = (ap_addr == KWU_OFS_POLARITY_SELECT);
    wire logic hit_im = (ap_addr == KWU_OFS_IRQ_MASK);
    wire logic wr_sc = dp_write & hit_sc;
    wire logic wr_pe = dp_write & hit_pe;
    wire logic wr_ps = dp_write & hit_ps;
    wire logic wr_im = dp_write & hit_im;
    // reads decode at address phase so data is ready in the data phase
    wire logic [11:0] rd_addr = haddr[11:0];
    wire logic rd_take = ap_valid & ~hwrite;
    wire logic rd_is = rd_take & (rd_addr == KWU_OFS_IRQ_STATUS);

    // ------------------------------------------------------------
    // detection
    // ------------------------------------------------------------
    logic [7:0] edge_hit; // per-pin valid edge
    logic [7:0] level_hit; // per-pin asserted level

    kwu_pin_detect u_detect
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(wake_input_pin),
        .pin_en(kbd_pin_enable),
        .pin_pol(kbd_polarity_select),
        .edge_hit(edge_hit),
        .level_hit(level_hit)
    );

    wire logic any_edge = |edge_hit;
    wire logic any_level = |level_hit;
    // level mode: an asserted level keeps setting the flag
    wire logic flag_set = any_edge | (edge_level_mode & any_level);
    // ack with a held level: the set term wins, so the flag stays
    wire logic ack = wr_sc & hwdata[KWU_BIT_ACK];
    wire logic next_flag = flag_set | (detect_flag & ~ack);
    wire logic [7:0] wr_pins = hwdata[7:0] & KWU_PIN_MASK;

    // ------------------------------------------------------------
    // flag and control registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            detect_flag <= 1'b0;
            irq_enable <= 1'b0;
            edge_level_mode <= 1'b0;
        end
        else
        begin
            detect_flag <= next_flag;
            if (wr_sc)
            begin
                irq_enable <= hwdata[KWU_BIT_IRQ_EN];
                edge_level_mode <= hwdata[KWU_BIT_MODE];
            end
        end
    end

    // pin configuration; no pull control lives here
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            kbd_pin_enable <= KWU_RST_PINS;
            kbd_polarity_select <= KWU_RST_PINS;
        end
        else
        begin
            if (wr_pe)
            begin
                kbd_pin_enable <= wr_pins;
            end
            if (wr_ps)
            begin
                kbd_polarity_select <= wr_pins;
            end
        end
    end

    // request to the cpu, gated by the enable bit
    assign kbd_irq = detect_flag & irq_enable;
    // stop mode: hclk assumed still running here; the request is combinational
    // from the live pins so a held level wakes even before the flag registers
    wire logic live_wake = (|(wake_input_pin ~^ kbd_polarity_select) & |kbd_pin_enable)
                           & (|((wake_input_pin ~^ kbd_polarity_select) & kbd_pin_enable & KWU_PIN_MASK));
    assign wake_request = stop_mode & irq_enable & (detect_flag | live_wake);

    // ------------------------------------------------------------
    // event status: edge and level events
    // ------------------------------------------------------------
    logic [1:0] evt_status; // sticky events
    logic [1:0] evt_mask; // event mask
    wire logic [1:0] evt_in = {edge_level_mode & any_level, any_edge};

    kwu_irq_status u_evt
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .evt(evt_in),
        .rd_clear(rd_is),
        .mask_we(wr_im),
        .mask_wdata(hwdata[1:0]),
        .status(evt_status),
        .mask(evt_mask),
        .irq(evt_irq)
    );

    // ------------------------------------------------------------
    // read mux; ack and reserved bits read zero
    // ------------------------------------------------------------
    wire logic [7:0] sc_read = {4'h0, detect_flag, 1'b0, irq_enable, edge_level_mode};
    wire logic [31:0] next_rdata =
        (rd_addr == KWU_OFS_STATUS_CONTROL) ? {24'h00_0000, sc_read} :
        (rd_addr == KWU_OFS_PIN_ENABLE) ? {24'h00_0000, kbd_pin_enable} :
        (rd_addr == KWU_OFS_POLARITY_SELECT) ? {24'h00_0000, kbd_polarity_select} :
        (rd_addr == KWU_OFS_IRQ_STATUS) ? {30'h0000_0000, evt_status} :
        (rd_addr == KWU_OFS_IRQ_MASK) ? {30'h0000_0000, evt_mask} :
        KWU_RST_RDATA;

    // ------------------------------------------------------------
    // bus phase tracking; zero wait states
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase <= KWU_PH_IDLE;
            ap_addr <= 12'h000;
            ap_write <= 1'b0;
            hrdata_q <= KWU_RST_RDATA;
        end
        else
        begin
            if (hready)
            begin
                phase <= ap_valid ? KWU_PH_DATA : KWU_PH_IDLE;
                ap_addr <= haddr[11:0];
                ap_write <= hwrite;
            end
            if (rd_take)
            begin
                hrdata_q <= next_rdata;
            end
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = KWU_HRESP_OKAY;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_flag_ro;
        @(posedge hclk) disable iff (!hresetn)
        (wr_sc & ~hwdata[KWU_BIT_ACK] & ~flag_set) |=> (detect_flag == $past(detect_flag));
    endproperty
    a_flag_ro: assert property (p_flag_ro)
        else $error("flag changed by plain write");

    property p_ack_reads_zero;
        @(posedge hclk) disable iff (!hresetn)
        (rd_take & (rd_addr == KWU_OFS_STATUS_CONTROL)) |=> (hrdata[KWU_BIT_ACK] == 1'b0);
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero)
        else $error("ack bit read back as one");

    // a write that clears the enable must silence the request next cycle
    property p_irq_gate;
        @(posedge hclk) disable iff (!hresetn)
        (wr_sc & ~hwdata[KWU_BIT_IRQ_EN]) |=> ~kbd_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq not gated by enable");

    property p_edge_mode_no_level;
        @(posedge hclk) disable iff (!hresetn)
        (~edge_level_mode & ~any_edge & ~detect_flag) |=> ~detect_flag;
    endproperty
    a_edge_mode_no_level: assert property (p_edge_mode_no_level)
        else $error("flag set by level in edge-only mode");

    property p_reserved_zero;
        @(posedge hclk) disable iff (!hresetn)
        ((kbd_pin_enable | kbd_polarity_select) & ~KWU_PIN_MASK) == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("unimplemented pin bit set");

    sequence s_edge_cause;
        any_edge ##1 1'b1;
    endsequence
    property p_edge_sets_flag;
        @(posedge hclk) disable iff (!hresetn)
        s_edge_cause |-> detect_flag;
    endproperty
    a_edge_sets_flag: assert property (p_edge_sets_flag)
        else $error("edge did not set flag");

    property p_level_holds_flag;
        @(posedge hclk) disable iff (!hresetn)
        (edge_level_mode & any_level & ack) |=> detect_flag;
    endproperty
    a_level_holds_flag: assert property (p_level_holds_flag)
        else $error("ack cleared flag with level held");

    property p_ack_clears;
        @(posedge hclk) disable iff (!hresetn)
        (ack & ~flag_set) |=> ~detect_flag;
    endproperty
    a_ack_clears: assert property (p_ack_clears)
        else $error("ack did not clear flag");

    property p_wake;
        @(posedge hclk) disable iff (!hresetn)
        (stop_mode & irq_enable & detect_flag) |-> wake_request;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake request in stop");
endmodule

// ### testbench/kwu_switch_model.sv
// switch model for the keypad wake unit: drives the wake pins
// assumes the bench sets wanted levels on rising hclk edges
`timescale 1ns/1ps
module kwu_switch_model
    import kwu_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [7:0] want,
    output logic [7:0] pins
);
    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    logic [7:0] junk; // pattern for lines with no switch behind them
    // switches settle one edge after the request; unused lines have no
    // pull, so they wander every cycle instead of holding a level
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            junk <= 8'h00;
            pins <= 8'hff;
        end
        else
        begin
            junk <= ~junk;
            pins <= (want & KWU_PIN_MASK) | (junk & ~KWU_PIN_MASK);
        end
    end
endmodule

// ### testbench/kwu_top_test.sv
// self-checking bench for the keypad wake unit
// assumes a zero-wait ahb-lite slave and the switch model on the pins
`timescale 1ns/1ps
module kwu_top_test;
    import kwu_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic hclk, hresetn, hsel, hwrite, stop_mode;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hready, hreadyout, hresp, kbd_irq, wake_request, evt_irq;
    logic [7:0] want, pins;
    int bad_count = 0;
    int compares = 0;
    // single-bit outputs gathered so a check can read them live after the edge
    localparam int OBS_IRQ = 0;
    localparam int OBS_WAKE = 1;
    localparam int OBS_EVT = 2;
    localparam int OBS_RESP = 3;
    wire logic [3:0] obs = {hresp, evt_irq, wake_request, kbd_irq};
    assign hready = hreadyout; // single slave drives the bus ready
    kwu_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .wake_input_pin(pins), .stop_mode(stop_mode),
        .kbd_irq(kbd_irq), .wake_request(wake_request), .evt_irq(evt_irq));
    kwu_switch_model sw (.hclk(hclk), .hresetn(hresetn), .want(want), .pins(pins));
    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // a hung handshake must still reach the verdict
    initial
    begin
        #400000;
        bad_count++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // bounded wait for hready high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                bad_count++;
                tally_and_finish();
            end
            @(posedge hclk);
        end
    endtask
    // one single word transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= KWU_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= KWU_HSIZE_WORD;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // output bits are read live just after the edge has settled, not copied
    // at the call, then the bench steps back onto the next rising edge
    task automatic chk_bit(input string name, input logic exp, input int idx);
        logic got;
        #1;
        got = obs[idx];
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
        @(posedge hclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask
    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0000_0000, v);
        chk(name, exp, v);
    endtask
    // new switch levels, then time for sampling and flag update
    task automatic pin_step(input logic [7:0] v);
        want <= v;
        repeat (4) @(posedge hclk);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0000_0000;
        want = 8'hff;
        stop_mode = 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values and the register map
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_0000);
        rd_chk("pin_enable", KWU_OFS_PIN_ENABLE, 32'h0000_0000);
        rd_chk("polarity_select", KWU_OFS_POLARITY_SELECT, 32'h0000_0000);
        rd_chk("irq_status", KWU_OFS_IRQ_STATUS, 32'h0000_0000);
        rd_chk("irq_mask", KWU_OFS_IRQ_MASK, 32'h0000_0000);
        chk_bit("kbd_irq", 1'b0, OBS_IRQ);
        chk_bit("hresp", KWU_HRESP_OKAY, OBS_RESP);
        wr(KWU_OFS_PIN_ENABLE, 32'h0000_00ff);
        rd_chk("pin_enable", KWU_OFS_PIN_ENABLE, 32'h0000_0037);
        wr(KWU_OFS_POLARITY_SELECT, 32'h0000_00ff);
        rd_chk("polarity_select", KWU_OFS_POLARITY_SELECT, 32'h0000_0037);
        rd_chk("unmapped", 12'h020, 32'h0000_0000);
        wr(KWU_OFS_PIN_ENABLE, 32'h0000_0000);
        // safe bring-up: mask, polarity, enable, acknowledge, unmask
        wr(KWU_OFS_STATUS_CONTROL, 32'h0000_0000);
        wr(KWU_OFS_POLARITY_SELECT, 32'h0000_0000);
        wr(KWU_OFS_PIN_ENABLE, 32'h0000_0001);
        wr(KWU_OFS_STATUS_CONTROL, 32'h0000_0004);
        wr(KWU_OFS_IRQ_MASK, 32'h0000_0003);
        wr(KWU_OFS_STATUS_CONTROL, 32'h0000_0002);
        // falling edge on pin 0 in edge-only mode
        pin_step(8'hfe);
        chk_bit("kbd_irq", 1'b1, OBS_IRQ);
        chk_bit("evt_irq", 1'b1, OBS_EVT);
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_000a);
        rd_chk("irq_status", KWU_OFS_IRQ_STATUS, 32'h0000_0001);
        chk_bit("evt_irq", 1'b0, OBS_EVT);
        // edge mode clears although the pin is still asserted
        wr(KWU_OFS_STATUS_CONTROL, 32'h0000_0006);
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_0002);
        // pin 0 released, disabled pin 1 falls
        pin_step(8'hfd);
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_0002);
        // enabling an already asserted pin gives no edge
        wr(KWU_OFS_PIN_ENABLE, 32'h0000_0003);
        pin_step(8'hfd);
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_0002);
        wr(KWU_OFS_STATUS_CONTROL, 32'h0000_000a);
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_0002);
        // rising polarity, request gated off, masked event
        wr(KWU_OFS_IRQ_MASK, 32'h0000_0000);
        wr(KWU_OFS_PIN_ENABLE, 32'h0000_0000);
        wr(KWU_OFS_POLARITY_SELECT, 32'h0000_0001);
        wr(KWU_OFS_PIN_ENABLE, 32'h0000_0001);
        wr(KWU_OFS_STATUS_CONTROL, 32'h0000_0000);
        pin_step(8'hfc);
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_0000);
        pin_step(8'hfd);
        chk_bit("kbd_irq", 1'b0, OBS_IRQ);
        chk_bit("evt_irq", 1'b0, OBS_EVT);
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_0008);
        rd_chk("irq_status", KWU_OFS_IRQ_STATUS, 32'h0000_0001);
        wr(KWU_OFS_STATUS_CONTROL, 32'h0000_0002);
        chk_bit("kbd_irq", 1'b1, OBS_IRQ);
        wr(KWU_OFS_STATUS_CONTROL, 32'h0000_0006);
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_0002);
        // edge and level mode, low level on pin 4
        wr(KWU_OFS_PIN_ENABLE, 32'h0000_0000);
        wr(KWU_OFS_POLARITY_SELECT, 32'h0000_0000);
        wr(KWU_OFS_PIN_ENABLE, 32'h0000_0010);
        wr(KWU_OFS_STATUS_CONTROL, 32'h0000_0007);
        pin_step(8'hed);
        chk_bit("kbd_irq", 1'b1, OBS_IRQ);
        wr(KWU_OFS_STATUS_CONTROL, 32'h0000_0007);
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_000b);
        stop_mode <= 1'b1;
        @(posedge hclk);
        chk_bit("wake_request", 1'b1, OBS_WAKE);
        stop_mode <= 1'b0;
        @(posedge hclk);
        chk_bit("wake_request", 1'b0, OBS_WAKE);
        pin_step(8'hfd);
        wr(KWU_OFS_STATUS_CONTROL, 32'h0000_0007);
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_0003);
        // a pin enabled while already low sets the flag by level alone
        wr(KWU_OFS_PIN_ENABLE, 32'h0000_0012);
        pin_step(8'hfd);
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_000b);
        wr(KWU_OFS_PIN_ENABLE, 32'h0000_0010);
        wr(KWU_OFS_STATUS_CONTROL, 32'h0000_0007);
        rd_chk("status_control", KWU_OFS_STATUS_CONTROL, 32'h0000_0003);
        tally_and_finish();
    end
endmodule
